// ==== rtl/dcs_pkg.sv ====
package dcs_pkg;

  // =====================================================================
  // Timing
  // =====================================================================
  localparam int unsigned CLK_PERIOD_NS   = 8;
  localparam int unsigned PWRUP_DELAY_MS  = 72;
  // A least time, so the count rounds up.
  localparam int unsigned PWRUP_CYCLES    =
    (PWRUP_DELAY_MS * 1_000_000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OST_CYCLES      = 1024;
  localparam int unsigned WDT_TICKS       = 256;
  localparam int unsigned CNT_W           = 24;
  localparam int unsigned WDT_W           = 16;

  // =====================================================================
  // Address space and configuration word
  // =====================================================================
  localparam int unsigned ADDR_W          = 14;
  localparam int unsigned DATA_W          = 14;
  localparam logic [13:0] CFG_WORD_ADDR   = 14'h2007;
  localparam logic [13:0] CFG_SPACE_LO    = 14'h2000;
  localparam logic [13:0] CFG_SPACE_HI    = 14'h3FFF;
  localparam logic [13:0] CFG_WORD_RESET  = 14'h3FFF;
  localparam logic [13:0] UNPROG_WORD     = 14'h3FFF;
  localparam logic [13:0] READ_ZERO       = 14'h0000;
  localparam int unsigned OSC_SEL_LO_POS  = 0;
  localparam int unsigned OSC_SEL_HI_POS  = 1;
  localparam int unsigned WDT_EN_POS      = 2;
  localparam int unsigned CP_LO_POS       = 4;
  localparam int unsigned CP_HI_POS       = 5;

  // First protected word of the 2K program memory for each level.
  localparam logic [11:0] PROT_BASE_OFF   = 12'h800;
  localparam logic [11:0] PROT_BASE_HALF  = 12'h400;
  localparam logic [11:0] PROT_BASE_3Q    = 12'h200;
  localparam logic [11:0] PROT_BASE_ALL   = 12'h000;

  typedef enum logic [1:0] {
    LOW_POWER_CRYSTAL_MODE  = 2'b00,
    CRYSTAL_RESONATOR_MODE  = 2'b01,
    HIGH_SPEED_CRYSTAL_MODE = 2'b10,
    RESISTOR_CAPACITOR_MODE = 2'b11
  } dcs_osc_type;

  typedef enum logic [1:0] {
    CP_ALL        = 2'b00,
    CP_UPPER_3Q   = 2'b01,
    CP_UPPER_HALF = 2'b10,
    CP_OFF        = 2'b11
  } dcs_cp_type;

  typedef enum logic [2:0] {
    ST_PWRUP  = 3'b000,
    ST_OST    = 3'b001,
    ST_RUN    = 3'b010,
    ST_SLEEP  = 3'b011,
    ST_EXTRST = 3'b100
  } dcs_state_type;

endpackage

// ==== rtl/dcs_config_startup.sv ====
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Configuration word sits at 2007h, outside the user program space.
// - Configuration bits read zero when programmed, one when unprogrammed.
// - Region 2000h to 3FFFh is reachable only in programming mode.
// - Code protect 11 none, 10 upper half, 01 upper 3/4, 00 all.
// - Watchdog enable bit one enables the watchdog, zero disables it.
// - Only the configuration bit can turn the watchdog off.
// - Watchdog counts ticks of its own RC oscillator.
// - Oscillator start-up timer holds reset until the crystal is stable.
// - Power-up delay of 72 ms holds reset, at power-up only.
// - Sleep ends on external reset, watchdog timeout or interrupt.
// - Two oscillator-select bits choose one of four oscillator modes.
module dcs_config_startup
  import dcs_pkg::*;
#(
  parameter int unsigned PWRUP_CYCLES_P = PWRUP_CYCLES,
  parameter int unsigned OST_CYCLES_P   = OST_CYCLES,
  parameter int unsigned WDT_TICKS_P    = WDT_TICKS
)(
  input  wire logic              CLK_IN,
  input  wire logic              RSTN_IN,
  input  wire logic              PROG_MODE_IN,
  input  wire logic [ADDR_W-1:0] ADDR_IN,
  input  wire logic [DATA_W-1:0] WDATA_IN,
  input  wire logic              WR_IN,
  input  wire logic              RD_IN,
  output logic      [DATA_W-1:0] RDATA_OUT,
  input  wire logic              EXT_RSTN_IN,
  input  wire logic              WDT_OSC_IN,
  input  wire logic              IRQ_IN,
  input  wire logic              SLEEP_REQ_IN,
  input  wire logic              WDT_CLEAR_IN,
  output logic      [1:0]        OSC_MODE_OUT,
  output logic                   WDT_ENABLE_OUT,
  output logic      [1:0]        CP_LEVEL_OUT,
  output logic      [11:0]       PROT_BASE_OUT,
  output logic                   CHIP_RESET_OUT,
  output logic                   SLEEP_OUT,
  output logic                   WAKE_OUT,
  output logic                   WDT_TIMEOUT_OUT
);

  // =====================================================================
  // Parameter checks
  // =====================================================================
  if (PWRUP_CYCLES_P < 1 || PWRUP_CYCLES_P >= (1 << CNT_W) ||
      OST_CYCLES_P < 1 || OST_CYCLES_P >= (1 << CNT_W) ||
      WDT_TICKS_P < 1 || WDT_TICKS_P >= (1 << WDT_W))
  begin : g_bad
    $error("dcs_config_startup: count parameter out of range");
  end

  localparam logic [CNT_W-1:0] PWRUP_LAST = CNT_W'(PWRUP_CYCLES_P - 1);
  localparam logic [CNT_W-1:0] OST_LAST   = CNT_W'(OST_CYCLES_P - 1);
  localparam logic [WDT_W-1:0] WDT_LAST   = WDT_W'(WDT_TICKS_P - 1);

  function automatic logic [11:0] prot_base(input logic [1:0] cp);
    unique case (cp)
      CP_OFF:        prot_base = PROT_BASE_OFF;
      CP_UPPER_HALF: prot_base = PROT_BASE_HALF;
      CP_UPPER_3Q:   prot_base = PROT_BASE_3Q;
      CP_ALL:        prot_base = PROT_BASE_ALL;
    endcase
  endfunction

  // =====================================================================
  // Pin synchronisers: prog mode, external reset, watchdog RC, interrupt
  // =====================================================================
  logic [3:0] meta_ff;
  logic [3:0] sync_ff;
  logic       wdt_osc_d_ff;

  always_ff @(posedge CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      meta_ff      <= 4'h1;
      sync_ff      <= 4'h1;
      wdt_osc_d_ff <= 1'b0;
    end
    else
    begin
      meta_ff      <= {IRQ_IN, WDT_OSC_IN, PROG_MODE_IN, EXT_RSTN_IN};
      sync_ff      <= meta_ff;
      wdt_osc_d_ff <= sync_ff[2];
    end
  end

  logic ext_rstn_s;
  logic prog_s;
  logic irq_s;
  logic wdt_tick;
  assign ext_rstn_s = sync_ff[0];
  assign prog_s     = sync_ff[1];
  assign irq_s      = sync_ff[3];
  assign wdt_tick   = sync_ff[2] && !wdt_osc_d_ff;

  // =====================================================================
  // Configuration word and its programming port
  // =====================================================================
  logic [DATA_W-1:0] cfg_word_ff;
  logic              cfg_hit;
  logic              space_hit;
  assign cfg_hit   = prog_s && (ADDR_IN == CFG_WORD_ADDR);
  assign space_hit = prog_s && (ADDR_IN >= CFG_SPACE_LO) &&
                     (ADDR_IN <= CFG_SPACE_HI);

  // Like EPROM cells, a write can only program bits to zero; only RSTN_IN
  // reloads the word with all ones, so an unprogrammed bit reads as one.
  always_ff @(posedge CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
      cfg_word_ff <= CFG_WORD_RESET;
    else if (WR_IN && cfg_hit)
      cfg_word_ff <= cfg_word_ff & WDATA_IN;
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
      RDATA_OUT <= READ_ZERO;
    else if (RD_IN && cfg_hit)
      RDATA_OUT <= cfg_word_ff;
    else if (RD_IN && space_hit)
      RDATA_OUT <= UNPROG_WORD;
    else
      RDATA_OUT <= READ_ZERO;
  end

  // =====================================================================
  // Decoded settings
  // =====================================================================
  logic [1:0] cp_field;
  assign cp_field = {cfg_word_ff[CP_HI_POS], cfg_word_ff[CP_LO_POS]};

  always_ff @(posedge CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      OSC_MODE_OUT   <= RESISTOR_CAPACITOR_MODE;
      WDT_ENABLE_OUT <= 1'b1;
      CP_LEVEL_OUT   <= CP_OFF;
      PROT_BASE_OUT  <= PROT_BASE_OFF;
    end
    else
    begin
      OSC_MODE_OUT   <= {cfg_word_ff[OSC_SEL_HI_POS],
                         cfg_word_ff[OSC_SEL_LO_POS]};
      WDT_ENABLE_OUT <= cfg_word_ff[WDT_EN_POS];
      CP_LEVEL_OUT   <= cp_field;
      PROT_BASE_OUT  <= prot_base(cp_field);
    end
  end

  // =====================================================================
  // Start-up and sleep sequencer
  // =====================================================================
  dcs_state_type     state_ff;
  dcs_state_type     nxt_state;
  logic [CNT_W-1:0]  cnt_ff;
  logic [WDT_W-1:0]  wdt_cnt_ff;
  logic              wdt_fire;
  logic              crystal;

  assign crystal  = (OSC_MODE_OUT != RESISTOR_CAPACITOR_MODE);
  assign wdt_fire = WDT_ENABLE_OUT && wdt_tick && (wdt_cnt_ff == WDT_LAST);

  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_PWRUP:
        if (cnt_ff == PWRUP_LAST)
          nxt_state = ST_OST;
      ST_OST:
        if (!ext_rstn_s)
          nxt_state = ST_EXTRST;
        else if (!crystal || cnt_ff == OST_LAST)
          nxt_state = ST_RUN;
      ST_RUN:
        if (!ext_rstn_s)
          nxt_state = ST_EXTRST;
        else if (wdt_fire)
          nxt_state = ST_OST;
        else if (SLEEP_REQ_IN)
          nxt_state = ST_SLEEP;
      ST_SLEEP:
        if (!ext_rstn_s)
          nxt_state = ST_EXTRST;
        else if (wdt_fire || irq_s)
          nxt_state = ST_OST;
      ST_EXTRST:
        // Other resets skip the power-up delay.
        if (ext_rstn_s)
          nxt_state = ST_OST;
      default:
        nxt_state = ST_PWRUP;
    endcase
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
      state_ff <= ST_PWRUP;
    else
      state_ff <= nxt_state;
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
      cnt_ff <= '0;
    else if (nxt_state != state_ff)
      cnt_ff <= '0;
    else if (state_ff == ST_PWRUP || state_ff == ST_OST)
      cnt_ff <= cnt_ff + CNT_W'(1);
  end

  // Only the configuration bit stops the watchdog; the core can clear it.
  always_ff @(posedge CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
      wdt_cnt_ff <= '0;
    else if (!WDT_ENABLE_OUT || WDT_CLEAR_IN || wdt_fire ||
             (state_ff != ST_RUN && state_ff != ST_SLEEP) ||
             (state_ff == ST_RUN && nxt_state == ST_SLEEP))
      wdt_cnt_ff <= '0;
    else if (wdt_tick)
      wdt_cnt_ff <= wdt_cnt_ff + WDT_W'(1);
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      CHIP_RESET_OUT  <= 1'b1;
      SLEEP_OUT       <= 1'b0;
      WAKE_OUT        <= 1'b0;
      WDT_TIMEOUT_OUT <= 1'b0;
    end
    else
    begin
      CHIP_RESET_OUT  <= (nxt_state != ST_RUN) && (nxt_state != ST_SLEEP);
      SLEEP_OUT       <= (nxt_state == ST_SLEEP);
      WAKE_OUT        <= (state_ff == ST_SLEEP) && (nxt_state != ST_SLEEP);
      WDT_TIMEOUT_OUT <= wdt_fire;
    end
  end

  // =====================================================================
  // Assertions
  // =====================================================================
  sequence cfg_rd_s;
    RD_IN && prog_s && ADDR_IN == CFG_WORD_ADDR;
  endsequence

  cfg_read_word_a: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    cfg_rd_s |=> RDATA_OUT == $past(cfg_word_ff))
    else $error("configuration word read back wrong");

  prog_write_clears_a: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    WR_IN && cfg_hit |=> cfg_word_ff == ($past(cfg_word_ff) & $past(WDATA_IN)))
    else $error("configuration write did not program bits");

  run_space_hidden_a: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    RD_IN && !prog_s |=> RDATA_OUT == READ_ZERO)
    else $error("configuration space visible outside programming");

  cp_base_map_a: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    CP_LEVEL_OUT == CP_UPPER_HALF |-> PROT_BASE_OUT == PROT_BASE_HALF)
    else $error("code protect half decodes wrong");

  wdt_held_off_a: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    !WDT_ENABLE_OUT |=> wdt_cnt_ff == '0 && !WDT_TIMEOUT_OUT)
    else $error("watchdog runs while disabled");

  osc_sel_decode_a: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    ##1 OSC_MODE_OUT == $past(cfg_word_ff[1:0]))
    else $error("oscillator select not decoded");

  ost_hold_a: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    state_ff == ST_OST && crystal && ext_rstn_s && cnt_ff < OST_LAST
    |=> state_ff == ST_OST && CHIP_RESET_OUT)
    else $error("start-up timer released early");

  pwrup_hold_a: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    state_ff == ST_PWRUP && cnt_ff != PWRUP_LAST |=> state_ff == ST_PWRUP)
    else $error("power-up delay cut short");

  sequence irq_in_sleep_s;
    state_ff == ST_SLEEP && ext_rstn_s && irq_s;
  endsequence

  irq_wake_a: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    irq_in_sleep_s |=> state_ff == ST_OST ##0 WAKE_OUT && !SLEEP_OUT)
    else $error("interrupt did not end sleep");

endmodule
`default_nettype wire

// ==== verification/dcs_programmer.sv ====
`timescale 1ns/10ps
`default_nettype none
// ======================================================================
// Programmer on the far side of the programming port
// ======================================================================
// Lines not being strobed carry the inverse of the last value, so a design
// that samples them outside a strobe sees garbage rather than stale data.
module dcs_programmer
(
  input  wire logic        clk_in,
  input  wire logic [13:0] rdata_in,
  output logic             prog_out,
  output logic [13:0]      addr_out,
  output logic [13:0]      wdata_out,
  output logic             wr_out,
  output logic             rd_out
);
  initial
  begin
    prog_out  = 1'b0;
    addr_out  = 14'h0000;
    wdata_out = 14'h0000;
    wr_out    = 1'b0;
    rd_out    = 1'b0;
  end

  task automatic set_prog(input logic b);
    @(posedge clk_in);
    prog_out <= b;
    repeat (3) @(posedge clk_in);
  endtask

  task automatic wr(input logic [13:0] a, input logic [13:0] d);
    @(posedge clk_in);
    addr_out  <= a;
    wdata_out <= d;
    wr_out    <= 1'b1;
    @(posedge clk_in);
    wr_out    <= 1'b0;
    addr_out  <= ~a;
    wdata_out <= ~d;
  endtask

  task automatic rd(input logic [13:0] a, output logic [13:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_out   <= 1'b1;
    @(posedge clk_in);
    rd_out   <= 1'b0;
    addr_out <= ~a;
    #1;
    d = rdata_in;
  endtask
endmodule
`default_nettype wire

// ==== verification/device_config_and_startup_test.sv ====
`timescale 1ns/10ps
`default_nettype none
module device_config_and_startup_test
  import dcs_pkg::*;
;
  logic clk, rstn, ext_rstn, wosc, irq, slp, wclr, prog, wr, rd;
  logic [13:0] addr, wdata, rdata, d, r;
  logic [1:0] osc, cp;
  logic [11:0] prot;
  logic wen, chip_rst, sleep, wake, wto;
  int miscompares, n_compared, n_to, n_wk, c, seed;

  // ====================================================================
  // Clock, design and programmer
  // ====================================================================
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  dcs_config_startup #(.PWRUP_CYCLES_P(20), .OST_CYCLES_P(8),
    .WDT_TICKS_P(4)) u_dcs_config_startup (.CLK_IN(clk), .RSTN_IN(rstn),
    .PROG_MODE_IN(prog), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
    .RD_IN(rd), .RDATA_OUT(rdata), .EXT_RSTN_IN(ext_rstn),
    .WDT_OSC_IN(wosc), .IRQ_IN(irq), .SLEEP_REQ_IN(slp),
    .WDT_CLEAR_IN(wclr), .OSC_MODE_OUT(osc), .WDT_ENABLE_OUT(wen),
    .CP_LEVEL_OUT(cp), .PROT_BASE_OUT(prot), .CHIP_RESET_OUT(chip_rst),
    .SLEEP_OUT(sleep), .WAKE_OUT(wake), .WDT_TIMEOUT_OUT(wto));

  dcs_programmer u_dcs_programmer (.clk_in(clk), .rdata_in(rdata),
    .prog_out(prog), .addr_out(addr), .wdata_out(wdata), .wr_out(wr),
    .rd_out(rd));

  always @(posedge clk)
  begin
    if (wto === 1'b1) n_to++;
    if (wake === 1'b1) n_wk++;
  end

  // ====================================================================
  // Checking helpers
  // ====================================================================
  function automatic logic [11:0] exp_prot(input logic [1:0] lvl);
    return (lvl == 2'b11) ? 12'h800 : (lvl == 2'b10) ? 12'h400 :
           (lvl == 2'b01) ? 12'h200 : 12'h000;
  endfunction

  task automatic chk(input logic [13:0] g, input logic [13:0] e);
    n_compared++;
    if (g !== e)
    begin
      $display("BAD t=%0t got %h exp %h", $time, g, e);
      miscompares++;
    end
  endtask

  task automatic stop_test;
    $display("compares %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic run_wait(output int n);
    n = 0;
    while (chip_rst !== 1'b0 && n < 60)
    begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  // Each tick is slow enough to survive the two-flop synchroniser.
  task automatic tick(input int n);
    repeat (n)
    begin
      wosc <= 1'b1;
      repeat (3) @(posedge clk);
      wosc <= 1'b0;
      repeat (3) @(posedge clk);
    end
    repeat (3) @(posedge clk);
    #1;
  endtask

  initial
  begin
    #200000;
    miscompares++;
    stop_test();
  end

  // ====================================================================
  // Main sequence: one pass for every decode value
  // ====================================================================
  initial
  begin
    {rstn, ext_rstn, wosc, irq, slp, wclr} = 6'b010000;
    seed = 77;
    miscompares = 0;
    n_compared = 0;
    n_to = 0;
    n_wk = 0;
    for (int m = 0; m < 4; m++)
    begin
      rstn <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk({osc, wen, cp}, 14'h001F);
      chk(prot, 14'h0800);
      rstn <= 1'b1;
      run_wait(c);
      chk(c >= 20 && c < 30, 14'h0001);
      u_dcs_programmer.set_prog(1'b1);
      u_dcs_programmer.rd(CFG_WORD_ADDR, r);
      chk(r, 14'h3FFF);
      u_dcs_programmer.rd(14'h2003, r);
      chk(r, 14'h3FFF);
      u_dcs_programmer.rd(14'h1FFF & 14'($random(seed)), r);
      chk(r, 14'h0000);
      d = 14'($random(seed));
      d[5:4] = m[1:0];
      d[2] = m[0];
      d[1:0] = m[1:0];
      u_dcs_programmer.wr(CFG_WORD_ADDR, d);
      u_dcs_programmer.rd(CFG_WORD_ADDR, r);
      chk(r, d);
      u_dcs_programmer.set_prog(1'b0);
      u_dcs_programmer.rd(CFG_WORD_ADDR, r);
      chk(r, 14'h0000);
      u_dcs_programmer.wr(CFG_WORD_ADDR, 14'h0000);
      repeat (2) @(posedge clk);
      #1;
      chk(osc, 14'(m[1:0]));
      chk(cp, 14'(m[1:0]));
      chk(prot, exp_prot(m[1:0]));
      chk(wen, m[0]);
      c = n_to;
      tick(3);
      wclr <= 1'b1;
      @(posedge clk);
      wclr <= 1'b0;
      tick(3);
      chk(14'(n_to - c), 14'h0000);
      tick(1);
      chk(14'(n_to - c), 14'(m[0]));
      run_wait(c);
      slp <= 1'b1;
      @(posedge clk);
      slp <= 1'b0;
      @(posedge clk);
      #1;
      chk(sleep, 1'b1);
      c = n_wk;
      if (m[0])
        tick(4);
      else
      begin
        irq <= 1'b1;
        repeat (6) @(posedge clk);
        irq <= 1'b0;
        #1;
      end
      chk({sleep, 13'(n_wk - c)}, 14'h0001);
      run_wait(c);
      ext_rstn <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
      chk(chip_rst, 1'b1);
      ext_rstn <= 1'b1;
      run_wait(c);
      chk(c < 20 && (m == 3 || c >= 8), 14'h0001);
    end
    stop_test();
  end
endmodule
`default_nettype wire
